//--- common/itf_defs.svh
// Constants of the instruction timing and flag block: offsets, fields,
// reset values and cycle counts. Assumes word-aligned AHB-Lite access.
`ifndef ITF_DEFS_SVH
`define ITF_DEFS_SVH

// register byte offsets
`define ITF_REG_CTRL 8'h00
`define ITF_REG_CMD 8'h04
`define ITF_REG_STAT 8'h08
`define ITF_REG_DATA 8'h0C
`define ITF_REG_CYCL 8'h10

// control fields and reset values
`define ITF_CTRL_TWO_STEP 0
`define ITF_CTRL_WD_EN 1
`define ITF_TWO_STEP_RST 1'b0
`define ITF_WD_EN_RST 1'b1

// command fields
`define ITF_CMD_OP_LSB 0
`define ITF_CMD_ADDR_LSB 8
`define ITF_CMD_BIT_LSB 12
`define ITF_CMD_IMM_LSB 16

// status fields
`define ITF_STAT_DROPPED 8

// timing
`define ITF_CLKS_PER_CYC 4
`define ITF_ONE_CYC 2'h1
`define ITF_LONG_CYC 2'h2

// data memory address that holds the program counter low byte
`define ITF_PCL_ADDR 4'h2

`endif

//--- common/itf_pkg.sv
// Types of the instruction timing and flag block.
// Assumes itf_defs.svh holds every number.
package itf_pkg;

  typedef enum logic [5:0] {
    op_nop, op_add_am, op_add_ma, op_add_ax, op_adc_am, op_adc_ma, op_sub_ax, op_sub_am,
    op_sub_ma, op_sbc_am, op_sbc_ma, op_decimal_adjust, op_and_am, op_or_am, op_xor_am,
    op_and_ma, op_or_ma, op_xor_ma, op_and_ax, op_or_ax, op_xor_ax, op_cpl_m, op_cpl_a,
    op_inc_a, op_inc_m, op_dec_a, op_dec_m, op_rr_a, op_rr_m, op_rrc_a, op_rrc_m, op_rl_a,
    op_rl_m, op_rlc_a, op_rlc_m, op_mov_am, op_mov_ma, op_mov_ax, op_bit_clr, op_bit_set,
    op_jump, op_skz_m, op_skz_a, op_skz_bit, op_sknz_bit, op_increment_skip,
    op_decrement_skip, op_inc_skip_a, op_dec_skip_a, op_call, op_return, op_return_ax,
    op_interrupt_return, op_table_read_current_page, op_table_read_final_page, op_clr_m,
    op_set_m, op_wd_clear, op_watchdog_preclear_first, op_watchdog_preclear_second,
    op_swap_m, op_swap_a, op_halt
  } itf_op_t;

  // gray-coded phase within one instruction cycle
  typedef enum logic [1:0] {ph0 = 2'b00, ph1 = 2'b01, ph2 = 2'b11, ph3 = 2'b10} itf_phase_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } itf_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } itf_ahb_rsp_t;

  typedef struct packed {
    itf_phase_t phase;
    logic busy;
    logic done1;
    logic [1:0] rem;
    logic [1:0] last_cyc;
    itf_op_t op;
    logic [3:0] addr;
    logic [2:0] bsel;
    logic [7:0] imm;
    logic dummy;
    logic [7:0] acc;
    logic carry_flag;
    logic nibble_carry_flag;
    logic zero_flag;
    logic sign_wrap_flag;
    logic expiry_flag;
    logic sleep_flag;
    logic skip_pend;
    logic [6:0] table_high_latch;
    logic first_seen;
    logic second_seen;
    logic [7:0] watchdog_counter;
    logic two_step;
    logic wd_en;
    logic dropped;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    logic hready;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic wd_clr;
    logic pcl_load;
    logic tbl_req;
    logic tbl_last;
  } itf_state_t;

endpackage

//--- hdl/itf_core.sv
// Instruction timing and flag engine with AHB-Lite register slave.
// Assumes a single bus master, word transfers, rom_data stable during table reads.
`include "itf_defs.svh"
module itf_core (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic rstn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire itf_pkg::itf_ahb_req_t ahb_req, // AHB-Lite request
  output itf_pkg::itf_ahb_rsp_t ahb_rsp, // AHB-Lite response
  input wire logic [14:0] rom_data, // program word for table reads
  output logic tbl_req, // table read in progress
  output logic tbl_last, // table read targets the last page
  output logic wd_clr, // pulse: watchdog counter cleared
  output logic pcl_load // pulse: program counter low written
);
  import itf_pkg::*;

  itf_state_t st;
  itf_state_t next_st;
  logic [7:0] mem_rdata;
  logic exec_now;

  itf_mem #(.AW(4), .DW(8)) u_mem (
    .clk_sys(clk_sys),
    .ce(ce),
    .we(st.mem_we),
    .waddr(st.addr),
    .wdata(st.mem_wdata),
    .raddr(st.addr),
    .rdata(mem_rdata)
  );

  // execution happens at the last phase of the first instruction cycle
  assign exec_now = ce && st.busy && !st.done1 && st.phase == ph3;

  // outputs other than the constant hresp come straight from state flops
  assign ahb_rsp.hreadyout = st.hready;
  assign ahb_rsp.hresp = 1'b0;
  assign ahb_rsp.hrdata = st.hrdata;
  assign tbl_req = st.tbl_req;
  assign tbl_last = st.tbl_last;
  assign wd_clr = st.wd_clr;
  assign pcl_load = st.pcl_load;

  // whole next-state computation
  always_comb
  begin
    logic [7:0] m;
    logic [7:0] opb;
    logic [7:0] res;
    logic [8:0] sum9;
    logic [4:0] low5;
    logic [4:0] hiv;
    logic [4:0] lov;
    logic cin;
    logic is_sub;
    logic wmem;
    logic acc_wr;
    logic skip;
    logic long_op;
    logic pclw;
    logic wd_done;
    logic [1:0] total;
    logic [31:0] rd;
    m = mem_rdata;
    opb = 8'h00;
    res = 8'h00;
    sum9 = 9'h000;
    low5 = 5'h00;
    hiv = 5'h00;
    lov = 5'h00;
    cin = 1'b0;
    is_sub = 1'b0;
    wmem = 1'b0;
    acc_wr = 1'b0;
    skip = 1'b0;
    long_op = 1'b0;
    pclw = 1'b0;
    wd_done = 1'b0;
    total = `ITF_ONE_CYC;
    rd = 32'h0000_0000;
    next_st = st;
    next_st.hready = 1'b1;
    next_st.mem_we = 1'b0;
    next_st.wd_clr = 1'b0;
    next_st.pcl_load = 1'b0;

    // address phase: register read data ahead of the data phase
    next_st.dph_wr = 1'b0;
    if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready)
    begin
      next_st.dph_wr = ahb_req.hwrite && ahb_req.haddr[31:8] == 24'h000000;
      next_st.dph_addr = ahb_req.haddr[7:0];
      if (ahb_req.haddr[31:8] == 24'h000000)
      begin
        case (ahb_req.haddr[7:0])
          `ITF_REG_CTRL: rd = {30'h0, st.wd_en, st.two_step};
          `ITF_REG_STAT: rd = {21'h0, st.second_seen, st.first_seen, st.dropped, st.skip_pend,
                               st.busy, st.sleep_flag, st.expiry_flag, st.sign_wrap_flag,
                               st.zero_flag, st.nibble_carry_flag, st.carry_flag};
          `ITF_REG_DATA: rd = {8'h00, st.watchdog_counter, 1'b0, st.table_high_latch, st.acc};
          `ITF_REG_CYCL: rd = {30'h0, st.last_cyc};
          default: rd = 32'h0000_0000; // unmapped and command read as zero
        endcase
      end
      next_st.hrdata = rd;
    end

    // data phase writes
    if (st.dph_wr)
    begin
      case (st.dph_addr)
        `ITF_REG_CTRL:
        begin
          next_st.two_step = ahb_req.hwdata[`ITF_CTRL_TWO_STEP];
          next_st.wd_en = ahb_req.hwdata[`ITF_CTRL_WD_EN];
        end
        `ITF_REG_STAT:
        begin
          if (ahb_req.hwdata[`ITF_STAT_DROPPED])
            next_st.dropped = 1'b0;
        end
        `ITF_REG_CMD:
        begin
          // a command during execution is dropped, not queued
          if (st.busy)
            next_st.dropped = 1'b1;
          else
          begin
            next_st.op = itf_op_t'(ahb_req.hwdata[`ITF_CMD_OP_LSB +: 6]);
            next_st.addr = ahb_req.hwdata[`ITF_CMD_ADDR_LSB +: 4];
            next_st.bsel = ahb_req.hwdata[`ITF_CMD_BIT_LSB +: 3];
            next_st.imm = ahb_req.hwdata[`ITF_CMD_IMM_LSB +: 8];
            next_st.busy = 1'b1;
            next_st.done1 = 1'b0;
            next_st.phase = ph0;
            next_st.dummy = st.skip_pend;
            next_st.skip_pend = 1'b0;
            next_st.tbl_req = !st.skip_pend &&
              (next_st.op == op_table_read_current_page ||
               next_st.op == op_table_read_final_page);
            next_st.tbl_last = next_st.op == op_table_read_final_page;
          end
        end
        default: ;
      endcase
    end

    // free-running watchdog count
    if (st.wd_en)
      next_st.watchdog_counter = st.watchdog_counter + 8'h01;

    // phase sequencing: four system clocks per instruction cycle
    if (st.busy)
    begin
      case (st.phase)
        ph0: next_st.phase = ph1;
        ph1: next_st.phase = ph2;
        ph2: next_st.phase = ph3;
        ph3: next_st.phase = ph0;
        default: next_st.phase = ph0;
      endcase
      if (st.phase == ph3 && st.done1)
      begin
        next_st.rem = st.rem - 2'h1;
        next_st.busy = st.rem != 2'h1;
      end
    end

    // execution: skipped instructions are dummies with no effects
    if (st.busy && !st.done1 && st.phase == ph3 && !st.dummy)
    begin
      is_sub = st.op inside {op_sub_ax, op_sub_am, op_sub_ma, op_sbc_am, op_sbc_ma};
      case (st.op)
        op_add_am, op_add_ma, op_add_ax, op_adc_am, op_adc_ma,
        op_sub_ax, op_sub_am, op_sub_ma, op_sbc_am, op_sbc_ma:
        begin
          opb = (st.op == op_add_ax || st.op == op_sub_ax) ? st.imm : m;
          opb = is_sub ? ~opb : opb;
          if (st.op inside {op_adc_am, op_adc_ma, op_sbc_am, op_sbc_ma})
            cin = st.carry_flag;
          else
            cin = is_sub;
          sum9 = {1'b0, st.acc} + {1'b0, opb} + {8'h00, cin};
          low5 = {1'b0, st.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
          res = sum9[7:0];
          next_st.carry_flag = sum9[8];
          next_st.nibble_carry_flag = low5[4];
          next_st.zero_flag = res == 8'h00;
          next_st.sign_wrap_flag = st.acc[7] == opb[7] && res[7] != st.acc[7];
          wmem = st.op inside {op_add_ma, op_adc_ma, op_sub_ma, op_sbc_ma};
          acc_wr = !wmem;
        end
        op_decimal_adjust:
        begin
          // carry alone records the adjust; other flags hold
          lov = {1'b0, st.acc[3:0]};
          if (lov > 5'h09 || st.nibble_carry_flag)
            lov = lov + 5'h06;
          hiv = {1'b0, st.acc[7:4]} + {4'h0, lov[4]};
          if (hiv > 5'h09 || st.carry_flag)
            hiv = hiv + 5'h06;
          res = {hiv[3:0], lov[3:0]};
          next_st.carry_flag = st.carry_flag | hiv[4];
          wmem = 1'b1;
        end
        op_and_am, op_and_ma, op_and_ax, op_or_am, op_or_ma, op_or_ax,
        op_xor_am, op_xor_ma, op_xor_ax, op_cpl_m, op_cpl_a:
        begin
          opb = st.op inside {op_and_ax, op_or_ax, op_xor_ax} ? st.imm : m;
          if (st.op inside {op_and_am, op_and_ma, op_and_ax})
            res = st.acc & opb;
          else if (st.op inside {op_or_am, op_or_ma, op_or_ax})
            res = st.acc | opb;
          else if (st.op inside {op_xor_am, op_xor_ma, op_xor_ax})
            res = st.acc ^ opb;
          else
            res = ~m;
          next_st.zero_flag = res == 8'h00;
          wmem = st.op inside {op_and_ma, op_or_ma, op_xor_ma, op_cpl_m};
          acc_wr = !wmem;
        end
        op_inc_a, op_inc_m, op_dec_a, op_dec_m:
        begin
          res = st.op inside {op_inc_a, op_inc_m} ? m + 8'h01 : m - 8'h01;
          next_st.zero_flag = res == 8'h00;
          wmem = st.op inside {op_inc_m, op_dec_m};
          acc_wr = !wmem;
        end
        op_rr_a, op_rr_m, op_rl_a, op_rl_m:
        begin
          // plain rotates leave every flag alone
          res = st.op inside {op_rr_a, op_rr_m} ? {m[0], m[7:1]} : {m[6:0], m[7]};
          wmem = st.op inside {op_rr_m, op_rl_m};
          acc_wr = !wmem;
        end
        op_rrc_a, op_rrc_m, op_rlc_a, op_rlc_m:
        begin
          if (st.op inside {op_rrc_a, op_rrc_m})
          begin
            res = {st.carry_flag, m[7:1]};
            next_st.carry_flag = m[0];
          end
          else
          begin
            res = {m[6:0], st.carry_flag};
            next_st.carry_flag = m[7];
          end
          wmem = st.op inside {op_rrc_m, op_rlc_m};
          acc_wr = !wmem;
        end
        // group below leaves carry, nibble carry, zero and sign-wrap flags alone
        op_mov_am: begin res = m; acc_wr = 1'b1; end
        op_mov_ma: begin res = st.acc; wmem = 1'b1; end
        op_mov_ax: begin res = st.imm; acc_wr = 1'b1; end
        op_bit_clr: begin res = m & ~(8'h01 << st.bsel); wmem = 1'b1; end
        op_bit_set: begin res = m | (8'h01 << st.bsel); wmem = 1'b1; end
        op_clr_m: begin res = 8'h00; wmem = 1'b1; end
        op_set_m: begin res = 8'hFF; wmem = 1'b1; end
        op_swap_m: begin res = {m[3:0], m[7:4]}; wmem = 1'b1; end
        op_swap_a: begin res = {m[3:0], m[7:4]}; acc_wr = 1'b1; end
        op_jump, op_call, op_return, op_interrupt_return: long_op = 1'b1;
        op_return_ax:
        begin
          res = st.imm;
          acc_wr = 1'b1;
          long_op = 1'b1;
        end
        op_table_read_current_page, op_table_read_final_page:
        begin
          res = rom_data[7:0];
          wmem = 1'b1;
          next_st.table_high_latch = rom_data[14:8];
          next_st.tbl_req = 1'b0;
          long_op = 1'b1;
        end
        op_skz_m: skip = m == 8'h00;
        op_skz_a:
        begin
          res = m;
          acc_wr = 1'b1;
          skip = m == 8'h00;
        end
        op_skz_bit: skip = !m[st.bsel];
        op_sknz_bit: skip = m[st.bsel];
        op_increment_skip, op_decrement_skip, op_inc_skip_a, op_dec_skip_a:
        begin
          res = st.op inside {op_increment_skip, op_inc_skip_a} ? m + 8'h01 : m - 8'h01;
          skip = res == 8'h00;
          wmem = st.op inside {op_increment_skip, op_decrement_skip};
          acc_wr = !wmem;
        end
        op_wd_clear:
        begin
          wd_done = !st.two_step;
        end
        op_watchdog_preclear_first, op_watchdog_preclear_second:
        begin
          // each pre-clear is remembered until its partner arrives
          if (st.two_step)
          begin
            if (st.op == op_watchdog_preclear_first)
              next_st.first_seen = 1'b1;
            else
              next_st.second_seen = 1'b1;
            wd_done = next_st.first_seen && next_st.second_seen;
          end
        end
        op_halt:
        begin
          next_st.expiry_flag = 1'b0;
          next_st.sleep_flag = 1'b1;
        end
        default: ; // no-operation and unused codes
      endcase
      if (wd_done)
      begin
        next_st.watchdog_counter = 8'h00;
        next_st.expiry_flag = 1'b0;
        next_st.sleep_flag = 1'b0;
        next_st.first_seen = 1'b0;
        next_st.second_seen = 1'b0;
        next_st.wd_clr = 1'b1;
      end
      if (wmem)
      begin
        next_st.mem_we = 1'b1;
        next_st.mem_wdata = res;
      end
      if (acc_wr)
        next_st.acc = res;
      pclw = wmem && st.addr == `ITF_PCL_ADDR;
      next_st.pcl_load = pclw;
      next_st.skip_pend = skip;
      // extensions add up; memory increment/decrement skips may reach three
      total = `ITF_ONE_CYC + {1'b0, long_op} + {1'b0, pclw} + {1'b0, skip};
    end

    // completion of the first instruction cycle
    if (st.busy && !st.done1 && st.phase == ph3)
    begin
      next_st.done1 = 1'b1;
      next_st.last_cyc = total;
      next_st.rem = total - 2'h1;
      next_st.busy = total != `ITF_ONE_CYC;
    end

    // a watchdog overflow wins over a clear in the same clock
    if (st.wd_en && st.watchdog_counter == 8'hFF)
      next_st.expiry_flag = 1'b1;
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.hready <= 1'b1;
      st.two_step <= `ITF_TWO_STEP_RST;
      st.wd_en <= `ITF_WD_EN_RST;
    end
    else if (ce)
      st <= next_st;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn || !ce);

  a_add_carry: assert property (exec_now && !st.dummy && st.op == op_add_ax |=>
    st.carry_flag == $past(({1'b0, st.acc} + {1'b0, st.imm}) > 9'h0FF))
    else $error("add carry wrong");
  a_adjust_only_c: assert property (exec_now && st.op == op_decimal_adjust |=>
    $stable(st.zero_flag) && $stable(st.nibble_carry_flag) && $stable(st.sign_wrap_flag))
    else $error("decimal adjust touched other flags");
  a_logic_zero: assert property (exec_now && st.op inside {op_and_ax, op_or_am, op_cpl_a} |=>
    $stable(st.carry_flag) && st.zero_flag == (st.acc == 8'h00))
    else $error("logic flag update wrong");
  a_incdec_zero: assert property (exec_now && st.op == op_inc_a |=>
    $stable(st.carry_flag) && $stable(st.sign_wrap_flag) && st.zero_flag == (st.acc == 8'h00))
    else $error("inc flag update wrong");
  a_rotate_plain: assert property (exec_now && st.op inside {op_rr_a, op_rl_a} |=>
    $stable(st.carry_flag) && $stable(st.zero_flag))
    else $error("plain rotate changed flags");
  a_move_flags: assert property (exec_now && st.op inside {op_mov_ax, op_swap_a, op_nop} |=>
    $stable({st.carry_flag, st.zero_flag, st.nibble_carry_flag, st.sign_wrap_flag}))
    else $error("move changed flags");
  a_branch_two: assert property (exec_now && !st.dummy && st.op inside {op_jump, op_call,
    op_return, op_return_ax, op_interrupt_return} |=> st.busy [*4] ##1 !st.busy)
    else $error("branch not two cycles");
  a_table_two: assert property (exec_now && !st.dummy && st.op == op_table_read_final_page &&
    st.addr != `ITF_PCL_ADDR |=> st.busy [*4] ##1 !st.busy)
    else $error("table read not two cycles");
  a_table_request: assert property (exec_now && !st.dummy && st.op inside
    {op_table_read_current_page, op_table_read_final_page} |-> tbl_req ##1 !tbl_req)
    else $error("table request not held");
  a_pcl_extend: assert property (exec_now && !st.dummy && st.op == op_clr_m &&
    st.addr == `ITF_PCL_ADDR |=> pcl_load ##0 st.busy [*4] ##1 !st.busy)
    else $error("pcl write not extended");
  a_skip_none: assert property (exec_now && !st.dummy && st.op == op_skz_m &&
    mem_rdata != 8'h00 |=> !st.busy && !st.skip_pend)
    else $error("untaken skip lengthened");
  a_skip_three: assert property (exec_now && !st.dummy && st.op == op_increment_skip &&
    st.addr == `ITF_PCL_ADDR && mem_rdata == 8'hFF |=> st.busy [*8] ##1 !st.busy)
    else $error("double extension missing");
  a_bit_skip: assert property (exec_now && !st.dummy && st.op == op_sknz_bit |=>
    st.skip_pend == $past(mem_rdata[st.bsel]))
    else $error("bit skip decision wrong");
  a_halt_flags: assert property (exec_now && !st.dummy && st.op == op_halt |=>
    !st.busy && st.sleep_flag && !st.expiry_flag)
    else $error("halt timing or flags wrong");
  a_one_step: assert property (exec_now && !st.dummy && st.op == op_wd_clear && !st.two_step |=>
    wd_clr && !st.sleep_flag && st.last_cyc == 2'h1)
    else $error("one-step clear failed");
  a_single_pre: assert property (exec_now && !st.dummy && st.two_step && !st.second_seen &&
    st.op == op_watchdog_preclear_first |=> !wd_clr && $stable(st.sleep_flag))
    else $error("lone pre-clear cleared watchdog");
  a_dummy_quiet: assert property (exec_now && st.dummy |=>
    !st.mem_we && $stable(st.acc) && $stable(st.zero_flag) && !st.busy)
    else $error("dummy cycle had effects");

  c_skip_taken: cover property (exec_now && st.op == op_skz_m && mem_rdata == 8'h00);
  c_dummy_run: cover property (exec_now && st.dummy);
  c_two_step_done: cover property (exec_now && st.two_step && st.first_seen &&
    st.op == op_watchdog_preclear_second);
  c_table_read: cover property (exec_now && st.op == op_table_read_current_page);
endmodule

//--- hdl/itf_mem.sv
// Small data memory for the instruction block, registered read port.
// Assumes one write and one read per clock, no reset of contents.
module itf_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic ce, // clock enable
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [DW-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read address
  output logic [DW-1:0] rdata // read data, registered
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // contents carry no reset; software preloads through move instructions
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      if (we)
        mem[waddr] <= wdata;
      rdata <= mem[raddr];
    end
  end
endmodule

//--- test/test_mcu_instruction_timing_flags.sv
// Self-checking bench of the instruction timing and flag block over its register bus.
// Assumes itf_defs.svh on the include path and itf_pkg compiled before this file.
`include "itf_defs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_mcu_instruction_timing_flags import itf_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [14:0] rom = 15'h0;
  logic [31:0] seed = 32'hF3A53C11;
  logic [31:0] rd, v;
  logic [7:0] a, b, c, r;
  logic [3:0] f;
  logic [1:0] cyc;
  logic [10:0] st;
  logic [23:0] dat;
  logic tbl_last;
  int n_mismatch = 0;
  int n_checks = 0;
  itf_ahb_req_t req;
  itf_ahb_rsp_t rsp;
  itf_op_t two [7] = '{op_jump, op_call, op_return, op_return_ax, op_interrupt_return,
    op_table_read_current_page, op_table_read_final_page};

  // the lone slave's hreadyout closes the hready loop
  assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
  always #12.5 clk_sys = ~clk_sys;

  itf_core dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .ahb_req(req), .ahb_rsp(rsp),
    .rom_data(rom), .tbl_req(), .tbl_last(tbl_last), .wd_clr(), .pcl_load());

  // repeatable random source
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected {sign_wrap, zero, nibble_carry, carry} of an add
  function logic [3:0] fl(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = x + y;
    return {(x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, (x[3:0] + y[3:0]) > 5'h0F, s[8]};
  endfunction

  // one single word transfer; entered just after a rising edge
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  // issue one command, wait out busy under a bound, then snapshot results
  task ex(input itf_op_t op, input logic [3:0] ad, input logic [2:0] bi, input logic [7:0] x);
    int i;
    bus(1'b1, `ITF_REG_CMD, {8'h00, x, 1'b0, bi, ad, 2'b00, op});
    // busy is already set on the edge the command lands; this wait only adds one edge of slack
    @(posedge clk_sys);
    i = 0;
    do
    begin
      bus(1'b0, `ITF_REG_STAT, 32'h0);
      i++;
    end while (rd[6] !== 1'b0 && i < 50);
    if (i == 50) n_mismatch++;
    bus(1'b0, `ITF_REG_CYCL, 32'h0);
    cyc = rd[1:0];
    bus(1'b0, `ITF_REG_STAT, 32'h0);
    st = rd[10:0];
    bus(1'b0, `ITF_REG_DATA, 32'h0);
    dat = rd[23:0];
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // 77 commands of some 15 to 23 clocks each; generous margin
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, `ITF_REG_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h2, rd)
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // stop the counter so a wrap cannot set expiry mid-test
    bus(1'b1, `ITF_REG_CTRL, 32'h0);
    $display("test registers done");
    repeat (8)
    begin
      v = rnd();
      a = v[7:0];
      b = v[15:8];
      c = v[23:16];
      ex(op_mov_ax, 4'h0, 3'h0, a);
      ex(op_add_ax, 4'h0, 3'h0, b);
      `CHK("add flags", fl(a, b), st[3:0])
      `CHK("add acc", a + b, dat[7:0])
      ex(op_and_ax, 4'h0, 3'h0, c);
      r = (a + b) & c;
      f = fl(a, b);
      f[2] = (r == 8'h00);
      `CHK("and flags", f, st[3:0])
      ex(op_mov_ma, 4'h4, 3'h0, 8'h00);
      ex(op_inc_a, 4'h4, 3'h0, 8'h00);
      `CHK("inc acc", r + 8'h01, dat[7:0])
      ex(op_swap_a, 4'h4, 3'h0, 8'h00);
      `CHK("swap acc", {r[3:0], r[7:4]}, dat[7:0])
      ex(op_rr_a, 4'h4, 3'h0, 8'h00);
      `CHK("rotate flags", {f[3], r == 8'hFF, f[1:0]}, st[3:0])
    end
    $display("test arithmetic done");
    foreach (two[i])
    begin
      v = rnd();
      rom <= v[14:0];
      ex(two[i], 4'h3, 3'h0, 8'h00);
      `CHK("long cycles", 2'h2, cyc)
    end
    `CHK("table latch", v[14:8], dat[14:8])
    `CHK("last page", 1'b1, tbl_last)
    ex(op_mov_am, 4'h3, 3'h0, 8'h00);
    `CHK("table low", v[7:0], dat[7:0])
    $display("test timing done");
    ex(op_mov_ax, 4'h0, 3'h0, 8'hFF);
    ex(op_mov_ma, `ITF_PCL_ADDR, 3'h0, 8'h00);
    `CHK("pcl write", 2'h2, cyc)
    ex(op_increment_skip, `ITF_PCL_ADDR, 3'h0, 8'h00);
    `CHK("skip and pcl", 2'h3, cyc)
    ex(op_mov_ax, 4'h0, 3'h0, 8'h5A);
    `CHK("dummy acc", 8'hFF, dat[7:0])
    ex(op_sknz_bit, `ITF_PCL_ADDR, 3'h7, 8'h00);
    `CHK("no skip", 2'h1, cyc)
    ex(op_skz_bit, `ITF_PCL_ADDR, 3'h7, 8'h00);
    `CHK("bit skip", 2'h2, cyc)
    ex(op_nop, 4'h0, 3'h0, 8'h00);
    ex(op_clr_m, `ITF_PCL_ADDR, 3'h0, 8'h00);
    `CHK("pcl clear", 2'h2, cyc)
    $display("test skip done");
    ex(op_halt, 4'h0, 3'h0, 8'h00);
    `CHK("halt cycles", 2'h1, cyc)
    `CHK("halt flags", 2'b10, st[5:4])
    ex(op_wd_clear, 4'h0, 3'h0, 8'h00);
    `CHK("one step", 2'b00, st[5:4])
    `CHK("counter", 8'h00, dat[23:16])
    ex(op_halt, 4'h0, 3'h0, 8'h00);
    bus(1'b1, `ITF_REG_CTRL, 32'h1);
    ex(op_watchdog_preclear_first, 4'h0, 3'h0, 8'h00);
    `CHK("first only", 2'b10, st[5:4])
    ex(op_watchdog_preclear_second, 4'h0, 3'h0, 8'h00);
    `CHK("both", 2'b00, st[5:4])
    $display("test watchdog done");
    conclude();
  end
endmodule
